// [hw/dcc_fifo.sv]
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes a single clock; reset is asynchronous, active low.
*/
`timescale 1ns/1ps
`default_nettype none
module dcc_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  assign in_ready_out = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid_out = wr_q != rd_q;
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule // dcc_fifo
`default_nettype wire

// [hw/dcc_pkg.sv]
/*
  Constants and types for the converter control register bank.
  Assumes 16-bit registers at byte-wide addresses reached over a
  four-wire serial link with 24-bit words.
*/
package dcc_pkg;
  localparam logic [7:0] ADDR_CONV_CTRL = 8'h31;
  localparam logic [7:0] ADDR_MAP_CRC = 8'h3e;
  localparam logic [15:0] CONV_CTRL_RESET = 16'h0000;
  localparam logic [15:0] MAP_CRC_RESET = 16'h0000;
  localparam int FREQ_LSB = 8;
  localparam int FREQ_MSB = 11;
  localparam int EN_BIT = 0;
  localparam logic [15:0] CONV_CTRL_MASK = 16'h0f01;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_SEED = 16'hffff;
  localparam int WORD_BITS = 24;
  localparam int FIFO_DEPTH = 32;
  localparam logic [2:0] OP_READ = 3'h5;
  localparam logic [2:0] OP_WRITE = 3'h3;

  typedef struct packed {
    logic write;
    logic [7:0] addr;
    logic [15:0] data;
  } dcc_cmd_t;

  typedef enum logic [3:0] {
    FR_3M76_4M10, FR_3M52_3M84, FR_3M30_3M59, FR_3M09_3M36,
    FR_2M89_3M15, FR_2M71_2M95, FR_2M53_2M76, FR_2M37_2M59,
    FR_2M22_2M42, FR_2M08_2M27, FR_1M95_2M12, FR_1M82_1M99,
    FR_1M71_1M86, FR_1M60_1M74, FR_1M50_1M63, FR_1M40_1M53
  } dcc_freq_range_t;
endpackage

// [hw/dcc_top.sv]
/*
  Converter control and register-map checksum bank behind a serial link.
  Assumes the host drives SCLK as a link clock (mode 1: shift out on rising,
  sample on falling) and the master clock on MCLK_IN; 24-bit words.
  Frame: word 0 = {op[2:0], addr[7:0], spare}, word 1 = {data[15:0], spare}.
*/
// Functional notes
// - Bits 11:8 of converter control select the modulator clock range.
// - Bit 0 of converter control enables the power converter; resets off.
// - Read-only 16-bit register-map checksum, zero during reset, then the checksum of the control word from the first clock.
// - Serial data output is released whenever chip select is high.
`timescale 1ns/1ps
`default_nettype none
module dcc_top
  import dcc_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic ARST_N_IN,
  input wire logic SCLK_IN,
  input wire logic CS_N_IN,
  input wire logic SDI_IN,
  output logic SDO_OUT,
  output logic SDO_OE_N_OUT,
  output logic CONVERTER_ENABLE_OUT,
  output dcc_pkg::dcc_freq_range_t CONVERTER_FREQ_RANGE_OUT
);
  import dcc_pkg::*;

  // Link domain: word 0 holds op[2:0] at [23:21] and addr[7:0] at [20:13],
  // word 1 holds the data at [23:8]. A read is answered in the second
  // word of the following frame, once the value has crossed.
  logic [23:0] sh_in_q;
  logic [5:0] bit_q;
  logic [23:0] cmd_word_q;
  logic have_cmd_q;
  logic [23:0] sh_out_q;
  logic req_tgl_q;
  logic [24:0] req_q;
  logic [15:0] rd_sync1_q;
  logic [15:0] rd_sync2_q;
  logic [15:0] rd_word_l;
  logic [2:0] op_w;
  logic full_w;
  logic frame_clr;

  assign full_w = bit_q == 6'(WORD_BITS - 1);
  assign op_w = cmd_word_q[23:21];
  // Deselect restarts the bit count, so a cut word cannot skew the bits of the next
  assign frame_clr = !ARST_N_IN || CS_N_IN;

  // Link words are sampled on the falling edge while selected
  always_ff @(negedge SCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sh_in_q <= '0;
    end else if (!CS_N_IN) begin
      sh_in_q <= {sh_in_q[22:0], SDI_IN};
    end
  end

  always_ff @(negedge SCLK_IN or posedge frame_clr) begin
    if (frame_clr) begin
      bit_q <= '0;
    end else begin
      bit_q <= full_w ? '0 : bit_q + 6'd1;
    end
  end

  // Words pair as command then data; a pending command survives deselect
  always_ff @(negedge SCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      cmd_word_q <= '0;
      have_cmd_q <= 1'b0;
    end else if (!CS_N_IN && full_w) begin
      if (!have_cmd_q) begin
        cmd_word_q <= {sh_in_q[22:0], SDI_IN};
      end
      have_cmd_q <= !have_cmd_q;
    end
  end

  // Request word is written with its toggle, long before the toggle is seen
  always_ff @(negedge SCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      req_q <= '0;
      req_tgl_q <= 1'b0;
    end else if (!CS_N_IN && full_w && have_cmd_q &&
                 (op_w == OP_WRITE || op_w == OP_READ)) begin
      req_q <= {op_w == OP_WRITE, cmd_word_q[20:13], sh_in_q[22:7]};
      req_tgl_q <= ~req_tgl_q;
    end
  end

  // Read data is held for many link cycles between requests; two stages
  // only guard against a value caught while it changes
  always_ff @(posedge SCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rd_sync1_q <= '0;
      rd_sync2_q <= '0;
    end else begin
      rd_sync1_q <= rd_word_l;
      rd_sync2_q <= rd_sync1_q;
    end
  end

  // The link clock stands still between frames, so the first word of a
  // frame still shows the older answer; the second word is current
  always_ff @(posedge SCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sh_out_q <= '0;
    end else if (bit_q == 6'd0) begin
      sh_out_q <= {rd_sync2_q, 8'h00};
    end else begin
      sh_out_q <= {sh_out_q[22:0], 1'b0};
    end
  end

  assign SDO_OUT = sh_out_q[23];
  assign SDO_OE_N_OUT = CS_N_IN;

  // Master clock domain
  logic [2:0] tgl_sync_q;
  logic [24:0] req_sync1_q;
  logic [24:0] req_sync2_q;
  logic fifo_in_valid;
  logic fifo_out_valid;
  logic [24:0] fifo_out_data;
  dcc_cmd_t cmd_w;
  logic [15:0] conv_ctrl_q;
  logic [15:0] map_crc_q;
  logic [15:0] crc_d;
  logic [15:0] rd_data_q;

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      tgl_sync_q <= '0;
    end else begin
      tgl_sync_q <= {tgl_sync_q[1:0], req_tgl_q};
    end
  end

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      req_sync1_q <= '0;
      req_sync2_q <= '0;
    end else begin
      req_sync1_q <= req_q;
      req_sync2_q <= req_sync1_q;
    end
  end

  // Request word is stable long before its toggle is seen twice synced
  assign fifo_in_valid = tgl_sync_q[2] != tgl_sync_q[1];

  // At the required frame spacing the FIFO never fills, so ready is unused
  dcc_fifo #(
    .WIDTH($bits(dcc_cmd_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(MCLK_IN),
    .arst_n_in(ARST_N_IN),
    .in_valid_in(fifo_in_valid),
    .in_ready_out(),
    .in_data_in(req_sync2_q),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(1'b1),
    .out_data_out(fifo_out_data)
  );

  assign cmd_w = dcc_cmd_t'(fifo_out_data);

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      conv_ctrl_q <= CONV_CTRL_RESET;
    end else if (fifo_out_valid && cmd_w.write &&
                 cmd_w.addr == ADDR_CONV_CTRL) begin
      conv_ctrl_q <= cmd_w.data & CONV_CTRL_MASK;
    end
  end

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rd_data_q <= '0;
    end else if (fifo_out_valid && !cmd_w.write) begin
      unique case (cmd_w.addr)
        ADDR_CONV_CTRL: rd_data_q <= conv_ctrl_q;
        ADDR_MAP_CRC: rd_data_q <= map_crc_q;
        default: rd_data_q <= '0;
      endcase
    end
  end

  // Checksum of the held control word, recomputed every cycle
  always_comb begin
    crc_d = CRC_SEED;
    for (int i = 15; i >= 0; i--) begin
      crc_d = {crc_d[14:0], 1'b0} ^
              ((crc_d[15] ^ conv_ctrl_q[i]) ? CRC_POLY : 16'h0000);
    end
  end

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      map_crc_q <= MAP_CRC_RESET;
    end else begin
      map_crc_q <= crc_d;
    end
  end

  assign rd_word_l = rd_data_q;
  assign CONVERTER_ENABLE_OUT = conv_ctrl_q[EN_BIT];
  assign CONVERTER_FREQ_RANGE_OUT =
    dcc_freq_range_t'(conv_ctrl_q[FREQ_MSB:FREQ_LSB]);
endmodule // dcc_top
`default_nettype wire

// [verification/dcc_checker.sv]
/* Checker for dcc_top ports.
   Assumes MCLK_IN domain and ARST_N_IN active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module dcc_checker
  import dcc_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic ARST_N_IN,
  input wire logic CS_N_IN,
  input wire logic SDO_OE_N_OUT,
  input wire logic CONVERTER_ENABLE_OUT,
  input wire dcc_pkg::dcc_freq_range_t CONVERTER_FREQ_RANGE_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // Eight idle cycles outlast the update latency of a write, and fit in
  // the gap that the host leaves between frames
  sequence s_quiet;
    CS_N_IN[*4] ##1 CS_N_IN[*4];
  endsequence
  a_en_idle_hold: assert property (
    s_quiet |-> $stable(CONVERTER_ENABLE_OUT))
    else $error("enable moved while link idle");
  a_freq_idle_hold: assert property (
    s_quiet |-> $stable(CONVERTER_FREQ_RANGE_OUT))
    else $error("range moved while link idle");
  a_reset_off: assert property (
    $rose(ARST_N_IN) |-> !CONVERTER_ENABLE_OUT
      && CONVERTER_FREQ_RANGE_OUT == FR_3M76_4M10)
    else $error("control not cleared by reset");
  a_sdo_release: assert property (
    CS_N_IN |-> SDO_OE_N_OUT)
    else $error("data out driven while deselected");
  a_sel_drive: assert property (
    !CS_N_IN |-> !SDO_OE_N_OUT)
    else $error("data out not driven while selected");
endmodule // dcc_checker
bind dcc_top dcc_checker u_chk (
  .MCLK_IN(MCLK_IN),
  .ARST_N_IN(ARST_N_IN),
  .CS_N_IN(CS_N_IN),
  .SDO_OE_N_OUT(SDO_OE_N_OUT),
  .CONVERTER_ENABLE_OUT(CONVERTER_ENABLE_OUT),
  .CONVERTER_FREQ_RANGE_OUT(CONVERTER_FREQ_RANGE_OUT)
);
`default_nettype wire

// [verification/dcc_host.sv]
/* Host controller model driving the serial link, mode 1.
   Assumes a 6 ns link clock that stands still between frames. */
`timescale 1ns/1ps
`default_nettype none
module dcc_host (
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out,
  input wire logic sdo_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  task automatic frame(input logic [47:0] tx, output logic [47:0] rx);
    cs_n_out = 1'b0;
    for (int i = 47; i >= 0; i--) begin
      #3 sclk_out = 1'b1;
      sdi_out = tx[i];
      #3 sclk_out = 1'b0;
      rx[i] = sdo_in;
    end
    #3 cs_n_out = 1'b1;
    // Released line must not look like held data
    sdi_out = ~sdi_out;
  endtask
endmodule // dcc_host
`default_nettype wire

// [verification/dcc_top_tb_top.sv]
/* Self-checking bench for dcc_top.
   Assumes dcc_host as link partner and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module dcc_top_tb_top;
  import dcc_pkg::*;
  logic mclk, arst_n, sdo, sdo_oe_n, en;
  wire logic sclk, cs_n, sdi, sdo_w;
  dcc_freq_range_t fr;
  logic [15:0] v;
  int error_cnt, total_checks, cyc;
  // Pull-up on the shared data-out line
  assign sdo_w = sdo_oe_n ? 1'b1 : sdo;
  dcc_top DUT (.MCLK_IN(mclk), .ARST_N_IN(arst_n), .SCLK_IN(sclk),
    .CS_N_IN(cs_n), .SDI_IN(sdi), .SDO_OUT(sdo),
    .SDO_OE_N_OUT(sdo_oe_n), .CONVERTER_ENABLE_OUT(en),
    .CONVERTER_FREQ_RANGE_OUT(fr));
  dcc_host host (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi),
    .sdo_in(sdo_w));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  function automatic logic [15:0] crc(input logic [15:0] d);
    logic [15:0] c;
    c = CRC_SEED;
    for (int i = 15; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  task gap;
    repeat (10) @(posedge mclk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    logic [47:0] rx;
    host.frame({OP_WRITE, a, 13'h0000, d, 8'h00}, rx);
    gap;
  endtask
  task rd(input logic [7:0] a, output logic [15:0] d);
    logic [47:0] rx;
    host.frame({OP_READ, a, 37'h0}, rx);
    gap;
    host.frame(48'h0, rx);
    gap;
    // The answer rides in the second word of the follow-up frame
    d = rx[23:8];
  endtask
  task t_reset;
    chk({15'h0000, en}, 16'h0000);
    chk({12'h000, fr}, 16'h0000);
    chk({15'h0000, sdo_oe_n}, 16'h0001);
    rd(ADDR_CONV_CTRL, v);
    chk(v, CONV_CTRL_RESET);
  endtask
  task t_codes;
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_CONV_CTRL, {4'h0, i[3:0], 7'h00, i[0]});
      chk({12'h000, fr}, {12'h000, i[3:0]});
      chk({15'h0000, en}, {15'h0000, i[0]});
    end
  endtask
  task t_mask_ro;
    wr(ADDR_CONV_CTRL, 16'hffff);
    rd(ADDR_CONV_CTRL, v);
    chk(v, 16'hffff & CONV_CTRL_MASK);
    rd(ADDR_MAP_CRC, v);
    chk(v, crc(16'hffff & CONV_CTRL_MASK));
    wr(ADDR_MAP_CRC, 16'h1234);
    rd(ADDR_MAP_CRC, v);
    chk(v, crc(16'hffff & CONV_CTRL_MASK));
    rd(8'h20, v);
    chk(v, 16'h0000);
    wr(ADDR_CONV_CTRL, 16'h0000);
    chk({15'h0000, en}, 16'h0000);
  endtask
  task t_reset_mid;
    wr(ADDR_CONV_CTRL, 16'h0f01);
    chk({15'h0000, en}, 16'h0001);
    chk({12'h000, fr}, 16'h000f);
    arst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1 arst_n = 1'b1;
    chk({15'h0000, en}, 16'h0000);
    chk({12'h000, fr}, 16'h0000);
    repeat (4) @(posedge mclk);
    #1;
    rd(ADDR_CONV_CTRL, v);
    chk(v, CONV_CTRL_RESET);
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      give_verdict;
    end
  end
  initial begin
    arst_n = 1'b0;
    repeat (12) @(posedge mclk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    t_reset;
    t_codes;
    t_mask_ro;
    t_reset_mid;
    give_verdict;
  end
endmodule // dcc_top_tb_top
`default_nettype wire
